//--- hw/wrse_defs.svh
/*
 Constants of the winder roll size estimator: register offsets, reset values,
 limits and timing. Assumes it is included by bare name after the package.
*/
// Function
// - estimate roll size as percent of full roll
// - calculate only above minimum web velocity
// - below threshold, hold last calculated size
// - preset enabled forces output to preset
// - preset loads filter state for restart
// - ramp limits full-scale change to ramp time
// - positive taper lowers demand hyperbolically
// - tension setpoint accepted from 0 to 100
// - signed trim added to tapered demand
// - friction settings signed, limited to 300
// - direction bit inverts friction compensation sign
// - speed inputs limited to 105 percent
// - raw size equals web over reel speed
// - tapered demand follows hyperbolic taper formula
// - unfiltered roll size exposed as monitor
`ifndef WRSE_DEFS_SVH
`define WRSE_DEFS_SVH
`define WRSE_CTRL_ADDR 8'h00
`define WRSE_MIN_SIZE_ADDR 8'h04
`define WRSE_MIN_SPEED_ADDR 8'h08
`define WRSE_PRESET_ADDR 8'h0c
`define WRSE_RAMP_ADDR 8'h10
`define WRSE_TAPER_ADDR 8'h14
`define WRSE_SPT_ADDR 8'h18
`define WRSE_TRIM_ADDR 8'h1c
`define WRSE_STATIC_ADDR 8'h20
`define WRSE_DYNAMIC_ADDR 8'h24
`define WRSE_SIZE_ADDR 8'h40
`define WRSE_RAW_ADDR 8'h44
`define WRSE_TAPERED_ADDR 8'h48
`define WRSE_TOTAL_ADDR 8'h4c
`define WRSE_COMP_ADDR 8'h50
`define WRSE_STATUS_ADDR 8'h54
`define WRSE_PRESET_BIT 0
`define WRSE_REWIND_BIT 1
`define WRSE_MIN_SIZE_RST 16'h03e8
`define WRSE_MIN_SPEED_RST 16'h01f4
`define WRSE_PRESET_RST 16'h03e8
`define WRSE_RAMP_RST 16'h0032
`define WRSE_FULL 16'h2710
`define WRSE_SPEED_LIM 16'h2904
`define WRSE_COMP_LIM 16'h7530
`define WRSE_RAMP_MIN 16'h0001
`define WRSE_RAMP_MAX 16'h1770
`define WRSE_REEL_GUARD 16'h000a
`define WRSE_OUT_LIM 20'h07fff
`define WRSE_RECIP_10K 32'h0000d1b7
`define WRSE_RECIP_SHIFT 29
`define WRSE_FRAC_BITS 16
`define WRSE_DIV_STEPS 6'h2f
`define WRSE_SAMPLE_US 1000
`define WRSE_CLK_MHZ 20
`define WRSE_RAMP_UNIT_US 100000
`define WRSE_RESP_OKAY 2'h0
`define WRSE_RESP_SLVERR 2'h2
`endif

//--- hw/wrse_pkg.sv
/*
 Types of the winder roll size estimator: percentage word, settings carrier,
 sequencer states. Assumes nothing beyond a SystemVerilog compiler.
*/
package wrse_pkg;
   // hundredths of a percent, signed
   typedef logic signed [15:0] wrse_pct_t;
   typedef struct packed {
      logic preset_en;
      logic rewind;
      wrse_pct_t min_size;
      wrse_pct_t min_speed;
      wrse_pct_t preset;
      wrse_pct_t ramp;
      wrse_pct_t taper;
      wrse_pct_t spt;
      wrse_pct_t trim;
      wrse_pct_t stat;
      wrse_pct_t dyn;
   } wrse_cfg_t;
   typedef enum logic [2:0] {WRSE_IDLE, WRSE_SIZE, WRSE_STEP, WRSE_PREP, WRSE_TAPER, WRSE_DONE} wrse_state_t;
endpackage

//--- hw/wrse_top.sv
/*
 Winder roll size estimator with taper, trim and friction compensation,
 configured and read over an AXI4-Lite slave.
 Assumes speed words come from another clock domain and change slowly
 compared with the sample tick; one clock aclk, synchronous active-low reset.
*/
`timescale 1ns/1ps
`include "wrse_defs.svh"
module wrse_top import wrse_pkg::*; #(
   parameter int SAMPLE_CYC = `WRSE_SAMPLE_US * `WRSE_CLK_MHZ
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [15:0] line_speed_in,
   input wire logic [15:0] reel_speed_in,
   output wrse_pct_t roll_size_out,
   output wrse_pct_t raw_roll_size_out,
   output wrse_pct_t total_pull_demand,
   output wrse_pct_t comp_demand_out,
   output logic calc_active
);
   localparam int TW = $clog2(SAMPLE_CYC);
   localparam logic [47:0] STEP_NUM = 48'(64'(10000) * 65536 * SAMPLE_CYC
      / (64'(`WRSE_CLK_MHZ) * `WRSE_RAMP_UNIT_US));
   localparam wrse_cfg_t CFG_RST = '{preset_en: 1'b0, rewind: 1'b1,
      min_size: `WRSE_MIN_SIZE_RST, min_speed: `WRSE_MIN_SPEED_RST, preset: `WRSE_PRESET_RST,
      ramp: `WRSE_RAMP_RST, default: 16'h0000};

   function automatic wrse_pct_t sat_rng(input logic signed [19:0] v, input logic signed [19:0] lo,
                                         input logic signed [19:0] hi);
      if (v > hi) return hi[15:0];
      else if (v < lo) return lo[15:0];
      else return v[15:0];
   endfunction

   function automatic wrse_pct_t sym(input logic signed [19:0] v, input logic [15:0] lim);
      return sat_rng(v, -20'(lim), 20'(lim));
   endfunction

   function automatic logic [15:0] abs16(input wrse_pct_t v);
      return v[15] ? 16'(-v) : v;
   endfunction

   // multiply by reciprocal: a true divide by 10000 would cost a second divider
   function automatic logic [15:0] div10k(input logic [31:0] x);
      logic [63:0] p;
      p = 64'(x) * 64'(`WRSE_RECIP_10K);
      return p[`WRSE_RECIP_SHIFT +: 16];
   endfunction

   function automatic wrse_pct_t merge(input wrse_pct_t old, input logic [31:0] d, input logic [3:0] s);
      return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   wrse_cfg_t cfg;
   wrse_state_t state;
   logic [TW-1:0] tick_cnt;
   logic tick;
   logic [15:0] line_s1, line_s2, line_s3, line_q, reel_s1, reel_s2, reel_s3, reel_q;
   logic aw_held, w_held, wr_fire;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic [31:0] rd_val;
   logic rd_ok, wr_ok;
   logic div_go, div_busy, div_done;
   logic [47:0] div_a, div_num;
   logic [15:0] div_b, div_den, div_rem;
   logic [5:0] div_cnt;
   logic [16:0] div_trial;
   logic [31:0] filt;
   logic [15:0] line_abs, reel_abs, size_now, size_m, tp;
   wrse_pct_t line_v, reel_v, tapered_q, total_q;
   logic signed [19:0] fric, comp;
   logic [16:0] factor;
   logic signed [33:0] diff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_cnt <= '0;
         tick <= 1'b0;
      end else if (tick_cnt == TW'(SAMPLE_CYC - 1)) begin
         tick_cnt <= '0;
         tick <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 1'b1;
         tick <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         line_s1 <= '0;
         line_s2 <= '0;
         reel_s1 <= '0;
         reel_s2 <= '0;
         line_s3 <= '0;
         reel_s3 <= '0;
         line_q <= '0;
         reel_q <= '0;
      end else begin
         line_s1 <= line_speed_in;
         line_s2 <= line_s1;
         reel_s1 <= reel_speed_in;
         reel_s2 <= reel_s1;
         line_s3 <= line_s2;
         reel_s3 <= reel_s2;
         // two equal samples in a row, so a torn word is never used
         if (line_s2 == line_s3) line_q <= line_s2;
         if (reel_s2 == reel_s3) reel_q <= reel_s2;
      end
   end

   always_comb begin
      line_v = sym(20'(signed'(line_q)), `WRSE_SPEED_LIM);
      reel_v = sym(20'(signed'(reel_q)), `WRSE_SPEED_LIM);
      line_abs = abs16(line_v);
      reel_abs = abs16(reel_v);
      size_now = filt[31:16];
      size_m = (size_now > cfg.min_size) ? size_now - cfg.min_size : 16'h0000;
      tp = div_num[15:0];
      factor = cfg.taper[15] ? 17'(`WRSE_FULL) + 17'(tp) : 17'(`WRSE_FULL) - 17'(tp);
      diff = 34'({raw_roll_size_out, 16'h0000}) - 34'(filt);
   end

   assign wr_fire = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held <= 1'b0;
      end else if (!aw_held && !s_axi_bvalid) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_wready <= 1'b0;
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held <= 1'b0;
      end else if (!w_held && !s_axi_bvalid) begin
         s_axi_wready <= 1'b1;
      end
   end

   always_comb begin
      wr_ok = (aw_addr <= `WRSE_DYNAMIC_ADDR) && (aw_addr[1:0] == 2'h0);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `WRSE_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ok ? `WRSE_RESP_OKAY : `WRSE_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // written values saturate into their legal range rather than erroring
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg <= CFG_RST;
      end else if (wr_fire) begin
         unique case (aw_addr)
            `WRSE_CTRL_ADDR: begin
               if (w_strb[0]) begin
                  cfg.preset_en <= w_data[`WRSE_PRESET_BIT];
                  cfg.rewind <= w_data[`WRSE_REWIND_BIT];
               end
            end
            `WRSE_MIN_SIZE_ADDR: cfg.min_size <= sat_rng(20'(merge(cfg.min_size, w_data, w_strb)), 20'h0, 20'(`WRSE_FULL));
            `WRSE_MIN_SPEED_ADDR: cfg.min_speed <= sat_rng(20'(merge(cfg.min_speed, w_data, w_strb)), 20'h0, 20'(`WRSE_FULL));
            `WRSE_PRESET_ADDR: cfg.preset <= sat_rng(20'(merge(cfg.preset, w_data, w_strb)), 20'h0, 20'(`WRSE_FULL));
            `WRSE_RAMP_ADDR: cfg.ramp <= sat_rng(20'(merge(cfg.ramp, w_data, w_strb)), 20'(`WRSE_RAMP_MIN), 20'(`WRSE_RAMP_MAX));
            `WRSE_TAPER_ADDR: cfg.taper <= sym(20'(merge(cfg.taper, w_data, w_strb)), `WRSE_FULL);
            `WRSE_SPT_ADDR: cfg.spt <= sat_rng(20'(merge(cfg.spt, w_data, w_strb)), 20'h0, 20'(`WRSE_FULL));
            `WRSE_TRIM_ADDR: cfg.trim <= sym(20'(merge(cfg.trim, w_data, w_strb)), `WRSE_FULL);
            `WRSE_STATIC_ADDR: cfg.stat <= sym(20'(merge(cfg.stat, w_data, w_strb)), `WRSE_COMP_LIM);
            `WRSE_DYNAMIC_ADDR: cfg.dyn <= sym(20'(merge(cfg.dyn, w_data, w_strb)), `WRSE_COMP_LIM);
            default: ;
         endcase
      end
   end

   always_comb begin
      rd_ok = 1'b1;
      rd_val = 32'h0;
      unique case (s_axi_araddr)
         `WRSE_CTRL_ADDR: rd_val = {30'h0, cfg.rewind, cfg.preset_en};
         `WRSE_MIN_SIZE_ADDR: rd_val = {16'h0, cfg.min_size};
         `WRSE_MIN_SPEED_ADDR: rd_val = {16'h0, cfg.min_speed};
         `WRSE_PRESET_ADDR: rd_val = {16'h0, cfg.preset};
         `WRSE_RAMP_ADDR: rd_val = {16'h0, cfg.ramp};
         `WRSE_TAPER_ADDR: rd_val = 32'(cfg.taper);
         `WRSE_SPT_ADDR: rd_val = {16'h0, cfg.spt};
         `WRSE_TRIM_ADDR: rd_val = 32'(cfg.trim);
         `WRSE_STATIC_ADDR: rd_val = 32'(cfg.stat);
         `WRSE_DYNAMIC_ADDR: rd_val = 32'(cfg.dyn);
         `WRSE_SIZE_ADDR: rd_val = {16'h0, roll_size_out};
         `WRSE_RAW_ADDR: rd_val = {16'h0, raw_roll_size_out};
         `WRSE_TAPERED_ADDR: rd_val = 32'(tapered_q);
         `WRSE_TOTAL_ADDR: rd_val = 32'(total_pull_demand);
         `WRSE_COMP_ADDR: rd_val = 32'(comp_demand_out);
         `WRSE_STATUS_ADDR: rd_val = {31'h0, calc_active};
         default: rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `WRSE_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_val;
         s_axi_rresp <= rd_ok ? `WRSE_RESP_OKAY : `WRSE_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

   // shared restoring divider, 48 quotient bits per start
   assign div_trial = {div_rem, div_num[47]};
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_busy <= 1'b0;
         div_done <= 1'b0;
         div_num <= '0;
         div_den <= '0;
         div_rem <= '0;
         div_cnt <= '0;
      end else if (div_go) begin
         div_busy <= 1'b1;
         div_done <= 1'b0;
         div_num <= div_a;
         div_den <= div_b;
         div_rem <= '0;
         div_cnt <= '0;
      end else if (div_busy) begin
         if (div_trial >= {1'b0, div_den}) begin
            div_rem <= 16'(div_trial - {1'b0, div_den});
            div_num <= {div_num[46:0], 1'b1};
         end else begin
            div_rem <= div_trial[15:0];
            div_num <= {div_num[46:0], 1'b0};
         end
         div_cnt <= div_cnt + 1'b1;
         div_busy <= (div_cnt != `WRSE_DIV_STEPS);
         div_done <= (div_cnt == `WRSE_DIV_STEPS);
      end else begin
         div_done <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= WRSE_IDLE;
         div_go <= 1'b0;
         div_a <= '0;
         div_b <= 16'h0001;
         filt <= {`WRSE_PRESET_RST, 16'h0000};
         raw_roll_size_out <= `WRSE_PRESET_RST;
         roll_size_out <= `WRSE_PRESET_RST;
         tapered_q <= '0;
         total_q <= '0;
         total_pull_demand <= '0;
         fric <= '0;
         comp_demand_out <= '0;
         calc_active <= 1'b0;
      end else begin
         div_go <= 1'b0;
         unique case (state)
            WRSE_IDLE: begin
               if (tick && cfg.preset_en) begin
                  raw_roll_size_out <= cfg.preset;
                  filt <= {cfg.preset, 16'h0000};
                  calc_active <= 1'b0;
                  state <= WRSE_PREP;
               end else if (tick && line_abs > cfg.min_speed) begin
                  calc_active <= 1'b1;
                  if (reel_abs < `WRSE_REEL_GUARD) begin
                     raw_roll_size_out <= `WRSE_FULL;
                     div_a <= STEP_NUM;
                     div_b <= cfg.ramp;
                     div_go <= 1'b1;
                     state <= WRSE_STEP;
                  end else begin
                     div_a <= 48'(line_abs) * 48'(`WRSE_FULL);
                     div_b <= reel_abs;
                     div_go <= 1'b1;
                     state <= WRSE_SIZE;
                  end
               end else if (tick) begin
                  calc_active <= 1'b0;
                  div_a <= STEP_NUM;
                  div_b <= cfg.ramp;
                  div_go <= 1'b1;
                  state <= WRSE_STEP;
               end
            end
            WRSE_SIZE: begin
               if (div_done) begin
                  if (div_num > 48'(`WRSE_FULL)) raw_roll_size_out <= `WRSE_FULL;
                  else if (div_num < 48'(cfg.min_size)) raw_roll_size_out <= cfg.min_size;
                  else raw_roll_size_out <= div_num[15:0];
                  div_a <= STEP_NUM;
                  div_b <= cfg.ramp;
                  div_go <= 1'b1;
                  state <= WRSE_STEP;
               end
            end
            WRSE_STEP: begin
               if (div_done) begin
                  if (diff >= 0 && 48'(diff) <= div_num) filt <= {raw_roll_size_out, 16'h0000};
                  else if (diff < 0 && 48'(-diff) <= div_num) filt <= {raw_roll_size_out, 16'h0000};
                  else if (diff >= 0) filt <= filt + div_num[31:0];
                  else filt <= filt - div_num[31:0];
                  state <= WRSE_PREP;
               end
            end
            WRSE_PREP: begin
               div_a <= 48'(abs16(cfg.taper)) * 48'(size_m);
               div_b <= (size_now == 16'h0000) ? 16'h0001 : size_now;
               div_go <= 1'b1;
               state <= WRSE_TAPER;
            end
            WRSE_TAPER: begin
               if (div_done) begin
                  // negative taper raises demand with size
                  tapered_q <= wrse_pct_t'(div10k(32'(cfg.spt) * 32'(factor)));
                  total_q <= sym(20'(wrse_pct_t'(div10k(32'(cfg.spt) * 32'(factor)))) + 20'(cfg.trim),
                                 `WRSE_COMP_LIM);
                  fric <= 20'(cfg.stat) + (cfg.dyn[15] ? -20'(div10k(32'(abs16(cfg.dyn)) * 32'(reel_abs)))
                                                      : 20'(div10k(32'(abs16(cfg.dyn)) * 32'(reel_abs))));
                  state <= WRSE_DONE;
               end
            end
            WRSE_DONE: begin
               roll_size_out <= size_now;
               total_pull_demand <= total_q;
               comp_demand_out <= sat_rng(comp, -`WRSE_OUT_LIM, `WRSE_OUT_LIM);
               state <= WRSE_IDLE;
            end
         endcase
      end
   end

   always_comb begin
      comp = 20'(total_q) + (cfg.rewind ? fric : -fric);
   end
endmodule

//--- tb/wrse_properties.sv
/*
 Concurrent checks on the roll size estimator's bus handshakes and outputs.
 Assumes it is bound to wrse_top and sees only that module's ports.
*/
`timescale 1ns/1ps
module wrse_properties import wrse_pkg::*; #(
   parameter int SAMPLE_CYC = 20000
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire wrse_pct_t roll_size_out,
   input wire wrse_pct_t raw_roll_size_out,
   input wire wrse_pct_t total_pull_demand,
   input wire wrse_pct_t comp_demand_out,
   input wire logic calc_active
);
   // one tick at the fastest ramp moves SAMPLE_CYC/200 hundredths
   localparam int MAX_STEP = SAMPLE_CYC / 200 + 1;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_write_answer: assert property (s_wr_take |=> !s_axi_awready && !s_axi_bvalid ##[1:2] s_axi_bvalid)
      else $error("write response not on time");
   a_read_answer: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
      else $error("read data not one cycle after address");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read data dropped early");
   a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while data pending");
   a_raw_bounds: assert property (raw_roll_size_out >= 0 && raw_roll_size_out <= 16'sd10000)
      else $error("raw roll size out of range");
   a_ramp_limit: assert property (calc_active && $changed(roll_size_out) |->
      roll_size_out - $past(roll_size_out) <= MAX_STEP && $past(roll_size_out) - roll_size_out <= MAX_STEP)
      else $error("roll size step too large");
   a_once_per_tick: assert property ($changed(total_pull_demand) |=> $stable(total_pull_demand) [*8])
      else $error("demand updated twice in a tick");
   a_reset_out: assert property (disable iff (1'b0) !aresetn |=> roll_size_out == 16'sh03e8 &&
      raw_roll_size_out == 16'sh03e8 && total_pull_demand == 0 && comp_demand_out == 0 && !calc_active)
      else $error("outputs not at reset values");
endmodule
bind wrse_top wrse_properties #(.SAMPLE_CYC(SAMPLE_CYC)) i_wrse_properties (.*);

//--- tb/wrse_speed_src.sv
/*
 Model of the line speed sensor and the drive's reel speed feedback.
 Assumes the bench commands target speeds in hundredths of a percent.
*/
`timescale 1ns/1ps
module wrse_speed_src (
   input wire logic aclk,
   input wire logic signed [15:0] line_cmd,
   input wire logic signed [15:0] reel_cmd,
   input wire logic slow,
   output logic [15:0] line_speed_in = 16'h0000,
   output logic [15:0] reel_speed_in = 16'h0000
);
   // slow mode slews like a real tacho, so the synchroniser sees ramps
   function automatic logic [15:0] move(logic [15:0] cur, logic signed [15:0] tgt, logic sl);
      int d;
      d = int'(tgt) - int'($signed(cur));
      if (!sl || (d < 256 && d > -256)) return tgt;
      return d > 0 ? cur + 16'h0100 : cur - 16'h0100;
   endfunction
   always @(posedge aclk) begin
      line_speed_in <= move(line_speed_in, line_cmd, slow);
      reel_speed_in <= move(reel_speed_in, reel_cmd, slow);
   end
endmodule

//--- tb/wrse_top_tb_top.sv
/*
 Self-checking bench for the roll size estimator: bus tasks, speeds through
 the sensor model, expectations from bench functions. Assumes a short tick.
*/
`timescale 1ns/1ps
module wrse_top_tb_top import wrse_pkg::*;;
   localparam int SC = 200;
   logic aclk = 0, aresetn = 0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, calc_active;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [31:0] s_axi_rdata, d;
   logic [15:0] line_speed_in, reel_speed_in;
   logic signed [15:0] line_cmd = 16'sh0, reel_cmd = 16'sh0;
   logic slow = 0;
   wrse_pct_t roll_size_out, raw_roll_size_out, total_pull_demand, comp_demand_out;
   int n_mismatch = 0, cmp_count = 0, cyc = 0, l, rr, prev, tp, v0;
   logic [31:0] rnd = 32'ha7a3;
   logic [7:0] dfa [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h40, 8'h44, 8'h4c, 8'h50, 8'h54};
   int dfv [10] = '{2, 1000, 500, 1000, 50, 1000, 1000, 0, 0, 0};
   logic [7:0] sa [5] = '{8'h14, 8'h18, 8'h1c, 8'h20, 8'h10};
   int sw [5] = '{12000, -5, 20000, -31000, 0};
   int se [5] = '{10000, 0, 10000, -30000, 1};
   int cl [9] = '{5000, -6000, 400, 500, 2000, 3000, 3000, 5250, 12000};
   int cr [9] = '{10000, -10000, 10000, 3000, 1000, 5, 10000, 20000, 10500};
   int cm [9] = '{1000, 1000, 1000, 1000, 1000, 1000, 4000, 1000, 1000};
   always #25 aclk = ~aclk;
   wrse_top #(.SAMPLE_CYC(SC)) i_wrse_top (.*);
   wrse_speed_src i_wrse_speed_src (.*);
   function automatic logic [31:0] lfsr(logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic int exp_raw(int ln, int rl, int mn, int pv);
      int q;
      ln = ln < 0 ? -ln : ln;
      rl = rl < 0 ? -rl : rl;
      ln = ln > 10500 ? 10500 : ln;
      rl = rl > 10500 ? 10500 : rl;
      if (ln <= 500) return pv;
      if (rl < 10) return 10000;
      q = ln * 10000 / rl;
      return q > 10000 ? 10000 : (q < mn ? mn : q);
   endfunction
   function automatic int exp_taper(int spt, int tpr, int s, int mn);
      return spt * (10000 - tpr * (s - mn) / s) / 10000;
   endfunction
   task complete_run;
      if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk_val(string nm, int e, logic [31:0] s, int tol);
      int df;
      df = int'($signed(s)) - e;
      cmp_count++;
      if (!(s === 32'(e) || (tol > 0 && !$isunknown(s) && df <= tol && df >= -tol))) begin
         n_mismatch++;
         $display("[FAIL] %s expected %0d seen %0d", nm, e, $signed(s));
      end
   endtask
   task automatic chk_resp(string nm, logic [1:0] e, logic [1:0] s);
      cmp_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %0h seen %0h", nm, e, s);
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      logic aw_ok, w_ok;
      aw_ok = 0;
      w_ok = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (!aw_ok && s_axi_awready) begin
            aw_ok = 1;
            s_axi_awvalid <= 0;
         end
         if (!w_ok && s_axi_wready) begin
            w_ok = 1;
            s_axi_wvalid <= 0;
         end
      end
      while (!s_axi_bvalid) @(posedge aclk);
      s_axi_bready <= 1;
      @(posedge aclk);
      rs = s_axi_bresp;
      s_axi_bready <= 0;
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      while (!s_axi_rvalid) @(posedge aclk);
      // late rready keeps the slave holding its data for a cycle
      s_axi_rready <= 1;
      @(posedge aclk);
      v = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 0;
   endtask
   task automatic wr(input logic [7:0] a, input int v, input logic [1:0] e);
      logic [1:0] rs;
      axi_wr(a, 32'(v), rs);
      chk_resp($sformatf("bresp %h", a), e, rs);
   endtask
   task automatic rd_chk(input logic [7:0] a, input int e, input int tol);
      logic [31:0] v;
      logic [1:0] rs;
      axi_rd(a, v, rs);
      chk_resp($sformatf("rresp %h", a), 2'h0, rs);
      chk_val($sformatf("reg %h", a), e, v, tol);
   endtask
   task automatic chk_defaults;
      for (int i = 0; i < 10; i++) rd_chk(dfa[i], dfv[i], 0);
   endtask
   task automatic settle;
      repeat (3 * SC) @(posedge aclk);
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_mismatch++;
         complete_run;
      end
   end
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      chk_defaults;
      axi_rd(8'h30, d, r);
      chk_resp("unmapped rresp", 2'h2, r);
      chk_val("unmapped rdata", 0, d, 0);
      wr(8'h44, 1, 2'h2);
      wr(8'h28, 1, 2'h2);
      for (int i = 0; i < 5; i++) begin
         wr(sa[i], sw[i], 2'h0);
         rd_chk(sa[i], se[i], 0);
      end
      line_cmd <= 16'sd100;
      reel_cmd <= 16'sd100;
      wr(8'h0c, 5000, 2'h0);
      wr(8'h18, 8000, 2'h0);
      wr(8'h14, 10000, 2'h0);
      wr(8'h1c, 500, 2'h0);
      wr(8'h20, 300, 2'h0);
      wr(8'h24, 1000, 2'h0);
      wr(8'h00, 3, 2'h0);
      settle;
      rd_chk(8'h40, 5000, 0);
      rd_chk(8'h44, 5000, 0);
      rd_chk(8'h54, 0, 0);
      tp = exp_taper(8000, 10000, 5000, 1000);
      rd_chk(8'h48, tp, 2);
      rd_chk(8'h4c, tp + 500, 2);
      rd_chk(8'h50, tp + 810, 2);
      wr(8'h00, 1, 2'h0);
      wr(8'h24, -1000, 2'h0);
      wr(8'h14, -5000, 2'h0);
      reel_cmd <= 16'sd5000;
      settle;
      tp = exp_taper(8000, -5000, 5000, 1000);
      rd_chk(8'h48, tp, 2);
      rd_chk(8'h50, tp + 500 + 200, 2);
      wr(8'h00, 2, 2'h0);
      prev = 5000;
      for (int i = 0; i < 9; i++) begin
         wr(8'h04, cm[i], 2'h0);
         line_cmd <= 16'(cl[i]);
         reel_cmd <= 16'(cr[i]);
         settle;
         prev = exp_raw(cl[i], cr[i], cm[i], prev);
         rd_chk(8'h44, prev, 1);
         rd_chk(8'h54, int'(cl[i] > 500 || cl[i] < -500), 0);
         if (i == 1) begin
            v0 = roll_size_out;
            repeat (SC) @(posedge aclk);
            chk_val("roll step", v0 + 1, 32'(roll_size_out), 0);
         end
      end
      slow <= 1;
      for (int i = 0; i < 6; i++) begin
         rnd = lfsr(rnd);
         l = 600 + int'(rnd[15:0]) % 9900;
         if (rnd[16]) l = -l;
         rnd = lfsr(rnd);
         rr = 1000 + int'(rnd[15:0]) % 9500;
         if (rnd[16]) rr = -rr;
         line_cmd <= 16'(l);
         reel_cmd <= 16'(rr);
         settle;
         prev = exp_raw(l, rr, 1000, prev);
         rd_chk(8'h44, prev, 1);
      end
      aresetn <= 0;
      repeat (3) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      chk_defaults;
      complete_run;
   end
endmodule
